// File: design/enc_counter.v
// Two quadrature counters, target table compare on counter 0, and
// capture of a selected counter on two sensor inputs.
// Assumes Wishbone classic master and inputs synchronous to clk_i.
`timescale 1ns/100ps
`include "enc_counter_consts.vh"
module enc_counter (
    input wire clk_i,
    input wire rst_i,
    input wire cyc_i,
    input wire stb_i,
    input wire we_i,
    input wire [7:0] adr_i,
    input wire [3:0] sel_i,
    input wire [31:0] dat_i,
    output reg [31:0] dat_o,
    output reg ack_o,
    input wire [1:0] encoder_phase_a_input_i,
    input wire [1:0] encoder_phase_b_input_i,
    input wire sensor_interrupt_input_a_i,
    input wire sensor_interrupt_input_b_i,
    input wire power_cycle_i,
    output wire irq_o,
    output reg task_req_o,
    output reg [15:0] task_num_o
);

// Byte-lane merge for writes
function [31:0] merge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0] be;
    integer k;
    begin
        merge = old;
        for (k = 0; k < 4; k = k + 1) begin
            if (be[k])
                merge[k*8 +: 8] = nw[k*8 +: 8];
        end
    end
endfunction

// Quadrature step: +1, -1 or 0 from old and new phase pairs
function [1:0] quad_step;
    input [1:0] prev;
    input [1:0] cur;
    begin
        case ({prev, cur})
        4'b0001, 4'b0111, 4'b1110, 4'b1000: quad_step = 2'b01;
        4'b0010, 4'b1011, 4'b1101, 4'b0100: quad_step = 2'b11;
        default: quad_step = 2'b00;
        endcase
    end
endfunction

// Sign-extend a step code to the counter width; codes are 00, 01, 11
function [31:0] step_delta;
    input [1:0] code;
    begin
        step_delta = {{30{code[1]}}, code};
    end
endfunction

// Table decode, shared by the write and read paths so that both agree
// on where entry n lives: value word at base + 8n, task word after it
function tbl_val_at;
    input [7:0] a;
    input integer n;
    begin
        tbl_val_at = ({24'h000000, a} == `ADDR_TBL_BASE + n * 8);
    end
endfunction

function tbl_task_at;
    input [7:0] a;
    input integer n;
    begin
        tbl_task_at = ({24'h000000, a} == `ADDR_TBL_BASE + n * 8 + 4);
    end
endfunction

// Register file and internal state
reg [31:0] ctrl;
reg [31:0] cfg_pend;
reg [31:0] cfg_act;
reg [`ST_BITS-1:0] status;
reg [`ST_BITS-1:0] mask;
reg [31:0] pv [0:`NUM_COUNTERS-1];
reg [1:0] ab_prev [0:`NUM_COUNTERS-1];
reg [31:0] cap_a;
reg [31:0] cap_b;
reg [7:0] tbl_cnt;
reg [31:0] tbl_val [0:`NUM_TARGETS-1];
reg [15:0] tbl_task [0:`NUM_TARGETS-1];
reg [1:0] rst_prev;
reg sens_a_prev;
reg sens_b_prev;
reg match_hit;
reg [15:0] match_task;
reg cmp_stop;
reg [1:0] pv_wr;
reg [31:0] next_dat;
// One loop index per process, so no variable has two drivers
integer i_cmp;
integer i_cnt;
integer i_wr;
integer i_rd;

// Bus decode and event sources
wire bus_req = cyc_i & stb_i & ~ack_o;
wire wr = bus_req & we_i;
wire cap_sel = cfg_act[`CFG_CAP_SEL];
wire [31:0] cap_src = cap_sel ? pv[1] : pv[0];
wire rise_a = sensor_interrupt_input_a_i & ~sens_a_prev;
wire rise_b = sensor_interrupt_input_b_i & ~sens_b_prev;
wire [`ST_BITS-1:0] events = {rise_b, rise_a, match_hit};
wire [`ST_BITS-1:0] clr_bits = (wr && adr_i == `ADDR_STATUS && sel_i[0])
    ? dat_i[`ST_BITS-1:0] : {`ST_BITS{1'b0}};

// Level interrupt; masked inputs never reach it
assign irq_o = |(status & mask);

// Table compare against counter 0, first hit wins
// Entries at or past the loaded count are ignored, so stale words
// left from an earlier table never fire
always @* begin
    match_hit = 1'b0;
    match_task = 16'h0000;
    for (i_cmp = `NUM_TARGETS - 1; i_cmp >= 0; i_cmp = i_cmp - 1) begin
        if (i_cmp < tbl_cnt && pv[0] == tbl_val[i_cmp] && !cmp_stop) begin
            match_hit = 1'b1;
            match_task = tbl_task[i_cmp];
        end
    end
end

// Software write strobe for each present value
// Writes take effect on the edge that accepts the request
always @* begin
    pv_wr[0] = wr && adr_i == `ADDR_PV0;
    pv_wr[1] = wr && adr_i == `ADDR_PV1;
end

// Counters: soft reset beats write beats gate beats counting
always @(posedge clk_i) begin
    if (rst_i) begin
        for (i_cnt = 0; i_cnt < `NUM_COUNTERS; i_cnt = i_cnt + 1) begin
            pv[i_cnt] <= 32'h00000000;
            ab_prev[i_cnt] <= 2'b00;
        end
        rst_prev <= 2'b00;
    end else begin
        rst_prev <= {ctrl[`CTRL_RST1], ctrl[`CTRL_RST0]};
        for (i_cnt = 0; i_cnt < `NUM_COUNTERS; i_cnt = i_cnt + 1) begin
            // Phases are sampled every clock: a pair that moves twice
            // between clocks is lost, so the edge rate must stay low
            ab_prev[i_cnt] <= {encoder_phase_a_input_i[i_cnt],
                encoder_phase_b_input_i[i_cnt]};
            if (ctrl[`CTRL_RST0 + i_cnt] && !rst_prev[i_cnt])
                pv[i_cnt] <= 32'h00000000; // Software-only reset
            else if (pv_wr[i_cnt])
                pv[i_cnt] <= merge(pv[i_cnt], dat_i, sel_i);
            else if (ctrl[`CTRL_GATE0 + i_cnt])
                pv[i_cnt] <= pv[i_cnt]; // Pulses ignored while gated
            else
                // Linear up/down count of x4 edges, wraps at 32 bits
                pv[i_cnt] <= pv[i_cnt] + step_delta(quad_step(
                    ab_prev[i_cnt], {encoder_phase_a_input_i[i_cnt],
                    encoder_phase_b_input_i[i_cnt]}));
        end
    end
end

// Compare halts after a soft reset of counter 0 unless continue is configured;
// a write to present value 0 re-arms it, since software has then
// set a fresh start point
always @(posedge clk_i) begin
    if (rst_i)
        cmp_stop <= 1'b0;
    else if (ctrl[`CTRL_RST0] && !rst_prev[0])
        cmp_stop <= ~cfg_act[`CFG_CONTINUE];
    else if (pv_wr[0])
        cmp_stop <= 1'b0;
end

// Sensor edge capture into separate latches
// Capture and status share one edge, so software sees both together
always @(posedge clk_i) begin
    if (rst_i) begin
        sens_a_prev <= 1'b0;
        sens_b_prev <= 1'b0;
        cap_a <= 32'h00000000;
        cap_b <= 32'h00000000;
    end else begin
        sens_a_prev <= sensor_interrupt_input_a_i;
        sens_b_prev <= sensor_interrupt_input_b_i;
        if (rise_a)
            cap_a <= cap_src;
        if (rise_b)
            cap_b <= cap_src;
    end
end

// Task request pulse; a match that lingers repeats each cycle, so
// software should act once per rising request
always @(posedge clk_i) begin
    if (rst_i) begin
        task_req_o <= 1'b0;
        task_num_o <= 16'h0000;
    end else begin
        task_req_o <= match_hit;
        if (match_hit)
            task_num_o <= match_task;
    end
end

// Sticky status; a set in the clearing cycle wins
// so that an event is never lost to a late clear
always @(posedge clk_i) begin
    if (rst_i)
        status <= {`ST_BITS{1'b0}};
    else
        status <= (status & ~clr_bits) | events;
end

// Register writes; the table is count first, then value and task
always @(posedge clk_i) begin
    if (rst_i) begin
        ctrl <= 32'h00000000;
        cfg_pend <= {30'h00000000, `CFG_RESET};
        cfg_act <= {30'h00000000, `CFG_RESET};
        mask <= {`ST_BITS{1'b0}};
        tbl_cnt <= 8'h00;
        for (i_wr = 0; i_wr < `NUM_TARGETS; i_wr = i_wr + 1) begin
            tbl_val[i_wr] <= 32'h00000000;
            tbl_task[i_wr] <= 16'h0000;
        end
    end else begin
        // Pending settings only take hold on a power cycle
        if (power_cycle_i)
            cfg_act <= cfg_pend;
        if (wr) begin
            case (adr_i)
            `ADDR_CTRL: ctrl <= merge(ctrl, dat_i, sel_i);
            `ADDR_CFG_PEND: cfg_pend <= merge(cfg_pend, dat_i, sel_i);
            `ADDR_MASK:
                if (sel_i[0])
                    mask <= dat_i[`ST_BITS-1:0];
            `ADDR_TBL_CNT:
                if (sel_i[0])
                    tbl_cnt <= dat_i[7:0];
            default: begin
                // Table words decode through the shared slot functions
                for (i_wr = 0; i_wr < `NUM_TARGETS; i_wr = i_wr + 1) begin
                    if (tbl_val_at(adr_i, i_wr))
                        tbl_val[i_wr] <= merge(tbl_val[i_wr], dat_i, sel_i);
                    if (tbl_task_at(adr_i, i_wr) && sel_i[0] && sel_i[1])
                        tbl_task[i_wr] <= dat_i[15:0];
                end
            end
            endcase
        end
    end
end

// Read mux; unmapped addresses read zero
always @* begin
    next_dat = 32'h00000000;
    case (adr_i)
    `ADDR_CTRL: next_dat = ctrl;
    `ADDR_CFG_PEND: next_dat = cfg_pend;
    `ADDR_CFG_ACT: next_dat = cfg_act;
    `ADDR_STATUS: next_dat = {29'h00000000, status};
    `ADDR_MASK: next_dat = {29'h00000000, mask};
    `ADDR_TASK: next_dat = {16'h0000, task_num_o};
    `ADDR_PV0: next_dat = pv[0];
    `ADDR_PV1: next_dat = pv[1];
    `ADDR_CAP_A: next_dat = cap_a;
    `ADDR_CAP_B: next_dat = cap_b;
    `ADDR_TBL_CNT: next_dat = {24'h000000, tbl_cnt};
    default: begin
        for (i_rd = 0; i_rd < `NUM_TARGETS; i_rd = i_rd + 1) begin
            if (tbl_val_at(adr_i, i_rd))
                next_dat = tbl_val[i_rd];
            if (tbl_task_at(adr_i, i_rd))
                next_dat = {16'h0000, tbl_task[i_rd]};
        end
    end
    endcase
end

// One-wait-state acknowledge, dropped the cycle after
// Read data is registered with ack, so the mux has a full cycle
always @(posedge clk_i) begin
    if (rst_i) begin
        ack_o <= 1'b0;
        dat_o <= 32'h00000000;
    end else begin
        ack_o <= bus_req;
        if (bus_req && !we_i)
            dat_o <= next_dat;
    end
end

endmodule // enc_counter

// File: design/enc_counter_consts.vh
// Constants for the encoder counter with target compare and capture.
// Assumes a classic Wishbone slave, 32-bit data, byte addresses.
`ifndef ENC_COUNTER_CONSTS_VH
`define ENC_COUNTER_CONSTS_VH
`define NUM_COUNTERS 2
`define NUM_TARGETS 4
`define ADDR_CTRL 8'h00
`define ADDR_CFG_PEND 8'h04
`define ADDR_CFG_ACT 8'h08
`define ADDR_STATUS 8'h0C
`define ADDR_MASK 8'h10
`define ADDR_TASK 8'h14
`define ADDR_PV0 8'h20
`define ADDR_PV1 8'h24
`define ADDR_CAP_A 8'h28
`define ADDR_CAP_B 8'h2C
`define ADDR_TBL_CNT 8'h30
`define ADDR_TBL_BASE 8'h40
`define CTRL_RST0 0
`define CTRL_RST1 1
`define CTRL_GATE0 8
`define CTRL_GATE1 9
`define CTRL_APPLY 31
`define CFG_CONTINUE 0
`define CFG_CAP_SEL 1
`define CFG_RESET 2'h1
`define ST_MATCH 0
`define ST_CAP_A 1
`define ST_CAP_B 2
`define ST_BITS 3
`define MAX_RATE_HZ 100000
`define CLK_HZ 20000000
`define MIN_EDGE_CYC (`CLK_HZ / `MAX_RATE_HZ / 4)
`endif

// File: test/enc_model.sv
// Encoder model: two A/B quadrature channels stepped on request.
// Assumes the caller waits until each step has finished.
`timescale 1ns/100ps
`include "enc_counter_consts.vh"
module enc_model (
    input wire clk_i,
    output reg [1:0] pha_o,
    output reg [1:0] phb_o
);
    reg [1:0] pos [0:1];
    initial begin
        pha_o = 2'h0;
        phb_o = 2'h0;
        pos[0] = 2'h0;
        pos[1] = 2'h0;
    end
    // Gray steps; the dwell keeps the edge rate in bounds
    task step(input int ch, input bit up, input int k);
        reg [1:0] p;
        repeat (k) begin
            p = up ? pos[ch] + 2'h1 : pos[ch] - 2'h1;
            pos[ch] = p;
            @(posedge clk_i);
            pha_o[ch] <= p[1];
            phb_o[ch] <= p[1] ^ p[0];
            repeat (`MIN_EDGE_CYC) @(posedge clk_i);
        end
    endtask
endmodule // enc_model

// File: test/enc_counter_assertions.sv
// Checker on the counter ports: bus timing, task and irq outputs.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/100ps
module enc_counter_assertions (
    input wire clk_i,
    input wire rst_i,
    input wire cyc_i,
    input wire stb_i,
    input wire ack_o,
    input wire irq_o,
    input wire task_req_o,
    input wire [15:0] task_num_o
);
    // One domain, so clock and reset are stated once
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    wire req = cyc_i && stb_i && !ack_o;
    property p_lat; req |=> ack_o; endproperty
    a_lat: assert property (p_lat) else $error("ack late");
    property p_one; ack_o |=> !ack_o; endproperty
    a_one: assert property (p_one) else $error("ack long");
    property p_cause; ack_o |-> $past(req); endproperty
    a_cause: assert property (p_cause) else $error("ack stray");
    property p_idle; !(cyc_i && stb_i) |=> !ack_o; endproperty
    a_idle: assert property (p_idle) else $error("ack idle");
    property p_cyc; ack_o |-> cyc_i && stb_i; endproperty
    a_cyc: assert property (p_cyc) else $error("ack no cyc");
    // A new task number only comes with a request
    property p_task;
        ($changed(task_num_o) && !$past(rst_i)) |-> task_req_o;
    endproperty
    a_task: assert property (p_task) else $error("task stray");
    property p_quiet; $fell(rst_i) |-> !ack_o && !task_req_o; endproperty
    a_quiet: assert property (p_quiet) else $error("busy reset");
    property p_irq0; $fell(rst_i) |-> !irq_o; endproperty
    a_irq0: assert property (p_irq0) else $error("irq reset");
    c_task: cover property (task_req_o);
    c_irq: cover property (irq_o);
    c_bus: cover property (req ##1 ack_o);
endmodule // enc_counter_assertions
bind enc_counter enc_counter_assertions enc_counter_assertions_i (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .ack_o(ack_o), .irq_o(irq_o), .task_req_o(task_req_o),
    .task_num_o(task_num_o));

// File: test/enc_counter_tb.sv
// Bench: Wishbone tasks drive the counter, the encoder model turns it.
// Assumes the model dwells long enough between encoder edges.
`timescale 1ns/100ps
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin n_fail++; \
    $display("BAD %s exp %h got %h", n, e, g); end end
module enc_counter_tb;
    reg clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0;
    reg [7:0] adr = 8'h0;
    reg [31:0] dat = 32'h0, rd;
    reg [2:0] ev = 3'h0;
    wire [31:0] q;
    wire ack, irq, treq;
    wire [15:0] tnum;
    wire [1:0] pa, pb;
    int checks = 0, n_fail = 0;
    enc_counter enc_counter_i (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc),
        .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(4'hF), .dat_i(dat),
        .dat_o(q), .ack_o(ack), .encoder_phase_a_input_i(pa),
        .encoder_phase_b_input_i(pb), .sensor_interrupt_input_a_i(ev[0]),
        .sensor_interrupt_input_b_i(ev[1]), .power_cycle_i(ev[2]),
        .irq_o(irq), .task_req_o(treq), .task_num_o(tnum));
    enc_model enc_model_i (.clk_i(clk_i), .pha_o(pa), .phb_o(pb));
    initial begin
        forever #25 clk_i = ~clk_i;
    end
    // Classic cycle: hold until ack is sampled, then one idle cycle
    task wb(input [7:0] a, input [31:0] d, input bit w = 1'b1);
        int n;
        begin
            n = 0;
            {cyc, stb, we, adr, dat} <= {2'h3, w, a, d};
            do begin
                @(posedge clk_i);
                n++;
            end while (ack !== 1'b1 && n < 50);
            rd = q;
            {cyc, stb} <= 2'h0;
            @(posedge clk_i);
            if (n >= 50) begin
                n_fail++;
                complete_run;
            end
        end
    endtask
    task chk(input string s, input [7:0] a, input [31:0] e);
        begin
            wb(a, 32'h0, 1'b0);
            `CHK(s, e, rd)
        end
    endtask
    // Sensor and power events are short pulses
    task pulse(input [2:0] m);
        begin
            ev <= m;
            @(posedge clk_i);
            ev <= 3'h0;
            repeat (3) @(posedge clk_i);
        end
    endtask
    task complete_run;
        begin
            $display("checks %0d n_fail %0d", checks, n_fail);
            if (n_fail == 0 && checks > 0)
                $display("ALL CHECKS OK");
            else
                $display("CHECKS NOT OK");
            $finish;
        end
    endtask
    initial begin
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        chk("cfg", 8'h08, 32'h1);
        chk("hole", 8'h18, 32'h0);
        wb(8'h30, 32'h2);
        wb(8'h40, 32'hBB8);
        wb(8'h44, 32'h8F);
        wb(8'h48, 32'hDAC);
        wb(8'h4C, 32'h90);
        wb(8'h10, 32'h1);
        wb(8'h20, 32'hBB6);
        enc_model_i.step(0, 1, 2);
        `CHK("task", 16'h8F, tnum)
        `CHK("req", 1'b1, treq)
        `CHK("irq", 1'b1, irq)
        enc_model_i.step(0, 1, 1);
        wb(8'h0C, 32'h1);
        `CHK("clr", 1'b0, irq)
        wb(8'h20, 32'hDAD);
        enc_model_i.step(0, 0, 1);
        `CHK("task2", 16'h90, tnum)
        wb(8'h00, 32'h100);
        enc_model_i.step(0, 1, 3);
        chk("gate", 8'h20, 32'hDAC);
        wb(8'h00, 32'h0);
        enc_model_i.step(0, 1, 1);
        chk("open", 8'h20, 32'hDAD);
        wb(8'h00, 32'h1);
        chk("zero", 8'h20, 32'h0);
        enc_model_i.step(1, 1, 2);
        chk("pv1", 8'h24, 32'h2);
        enc_model_i.step(0, 1, 3);
        wb(8'h0C, 32'h7);
        pulse(3'h1);
        `CHK("mask", 1'b0, irq)
        chk("capa", 8'h28, 32'h3);
        enc_model_i.step(0, 0, 1);
        pulse(3'h2);
        chk("capb", 8'h2C, 32'h2);
        chk("stat", 8'h0C, 32'h6);
        wb(8'h10, 32'h2);
        `CHK("unmask", 1'b1, irq)
        wb(8'h04, 32'h2);
        chk("held", 8'h08, 32'h1);
        pulse(3'h4);
        chk("new", 8'h08, 32'h2);
        enc_model_i.step(0, 1, 2);
        pulse(3'h1);
        chk("sel", 8'h28, 32'h2);
        // Continue is now off: a soft reset halts compare until pv0 write
        wb(8'h40, 32'h1);
        wb(8'h00, 32'h0);
        wb(8'h00, 32'h1);
        wb(8'h0C, 32'h7);
        enc_model_i.step(0, 1, 1);
        chk("stop", 8'h0C, 32'h0);
        `CHK("noreq", 1'b0, treq)
        wb(8'h20, 32'h0);
        enc_model_i.step(0, 1, 1);
        `CHK("resume", 16'h8F, tnum)
        `CHK("rereq", 1'b1, treq)
        complete_run;
    end
    // A hang counts as a mismatch
    initial begin
        repeat (20000) @(posedge clk_i);
        n_fail++;
        complete_run;
    end
endmodule // enc_counter_tb
